// >>> src/ris_map.vh
`ifndef RIS_MAP_VH
`define RIS_MAP_VH

// register byte offsets, one aligned 32-bit word each
`define RIS_OFS_EXT_IRQ2 12'h000
`define RIS_OFS_TIMER2_CLK 12'h004
`define RIS_OFS_CAPTURE_1_2 12'h008
`define RIS_OFS_CAPTURE_3_4 12'h00C
`define RIS_OFS_COMPARE_FAULT 12'h010
`define RIS_OFS_PWM_FAULT 12'h014
`define RIS_OFS_SERIAL1_RX 12'h018
`define RIS_OFS_SERIAL2_RX 12'h01C
`define RIS_OFS_SPI2_CLK_DATA 12'h020
`define RIS_OFS_ROUTED_LEVELS 12'h024

// selector field positions inside a register
`define RIS_FIELD_LO_LSB 0
`define RIS_FIELD_HI_LSB 8
`define RIS_FIELD_W 8

// reset value of every selector field
`define RIS_SEL_RESET 8'h00

// selection encoding
`define RIS_CODE_GROUND 8'h00
`define RIS_CODE_COMPARATOR 8'h01
`define RIS_CODE_FIRST_PIN 8'h02
`define RIS_CODE_MAX 8'hB5

// pin levels pass two flip-flops before any selector looks at them
`define RIS_SYNC_STAGES 2

`endif

// >>> src/ris_source_mux.v
`timescale 1ns/100ps
`include "ris_map.vh"

module ris_source_mux #(
  parameter PIN_HI = 181 // highest remappable pin code
) (
  input wire [7:0] selCode, // selector field value
  input wire [PIN_HI:2] pinLevel, // synchronized remappable pin levels
  input wire cmpLevel, // synchronized comparator one level
  output wire routed // level handed to the peripheral input
);

  function routeOf;
    input [7:0] code;
    input [PIN_HI:2] pins;
    input cmp;
    begin
      if (code == `RIS_CODE_GROUND) begin
        routeOf = 1'b0; // R10
      end else if (code == `RIS_CODE_COMPARATOR) begin
        routeOf = cmp; // R11
      end else if (code <= PIN_HI) begin
        // code n names pin n, so the top code reaches pin 181
        routeOf = pins[code]; // R12 R17
      end else begin
        routeOf = 1'b0; // R17
      end
    end
  endfunction

  assign routed = routeOf(selCode, pinLevel, cmpLevel); // R18

endmodule

// >>> src/ris_input_select.v
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "ris_map.vh"

// Functional notes
// R1 - low byte selects external interrupt two source
// R2 - low byte selects timer2 external clock source
// R3 - capture pairs: lower channel low byte
// R4 - low byte selects compare fault A source
// R5 - pwm fault1 low byte, fault2 high
// R6 - low byte selects first serial receive source
// R7 - low byte selects second serial receive source
// R8 - spi2 clock high byte, data low byte
// R9 - spi2 data input follows its selector
// R10 - code zero ties input low
// R11 - code one routes comparator one
// R12 - top code routes remappable pin 181
// R13 - single-selector registers: upper byte zero, ignored
// R14 - unimplemented bits always read zero
// R15 - reset clears every selector field
// R16 - many inputs may share one pin
// R17 - codes map to pins; undefined codes low
// R18 - mux of synced levels, effective next cycle
// R19 - reads return last written field values
module ris_input_select #(
  parameter ADDR_W = 12, // apb address width
  parameter PIN_HI = 181 // highest remappable pin code
) (
  input wire sys_clk, // system clock, 25 MHz
  input wire rst, // synchronous reset, active high
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction, high for write
  input wire [ADDR_W-1:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  input wire [3:0] pstrb, // apb write byte strobes
  output wire pready, // apb ready, always high
  output reg [31:0] prdata, // apb read data
  output wire pslverr, // apb error for unmapped address
  input wire [PIN_HI:2] remappablePin, // remappable input pin levels
  input wire comparatorOneOutput, // comparator one output level
  output wire externalInterruptTwo, // routed external interrupt two
  output wire timer2ExternalClock, // routed timer2 external clock
  output wire captureInput1, // routed capture 1 input
  output wire captureInput2, // routed capture 2 input
  output wire captureInput3, // routed capture 3 input
  output wire captureInput4, // routed capture 4 input
  output wire compareFaultAInput, // routed compare fault A
  output wire pwmFault1Input, // routed pwm fault 1
  output wire pwmFault2Input, // routed pwm fault 2
  output wire serial1ReceiveInput, // routed first serial receive
  output wire serial2ReceiveInput, // routed second serial receive
  output wire spi2DataInput, // routed spi2 serial data in
  output wire spi2ClockInput // routed spi2 serial clock in
);

  localparam NUM_SEL = 13;
  localparam [3:0] REG_LEVELS = 4'd9;
  localparam [3:0] REG_NONE = 4'hF;
  localparam [3:0] SEL_NONE = 4'hF;

  // selector slots
  localparam [3:0] S_IRQ2 = 4'd0;
  localparam [3:0] S_T2CLK = 4'd1;
  localparam [3:0] S_CAP1 = 4'd2;
  localparam [3:0] S_CAP2 = 4'd3;
  localparam [3:0] S_CAP3 = 4'd4;
  localparam [3:0] S_CAP4 = 4'd5;
  localparam [3:0] S_CMPF = 4'd6;
  localparam [3:0] S_FLT1 = 4'd7;
  localparam [3:0] S_FLT2 = 4'd8;
  localparam [3:0] S_SER1 = 4'd9;
  localparam [3:0] S_SER2 = 4'd10;
  localparam [3:0] S_SPID = 4'd11;
  localparam [3:0] S_SPIC = 4'd12;

  reg [7:0] selField [0:NUM_SEL-1];
  reg [PIN_HI:2] pinMeta;
  reg [PIN_HI:2] pinSync;
  reg cmpMeta;
  reg cmpSync;
  wire [NUM_SEL-1:0] routedAll;
  wire setupPhase;
  wire accessWrite;
  reg errFlag;
  reg [31:0] next_prdata;
  wire [3:0] setupReg;
  wire [3:0] accessReg;
  integer i;
  reg [NUM_SEL-1:0] loWrite;
  reg [NUM_SEL-1:0] hiWrite;
  integer j;

  // register index for an address, REG_NONE when unmapped
  function [3:0] regOf;
    input [ADDR_W-1:0] addr;
    begin
      case (addr)
        `RIS_OFS_EXT_IRQ2: regOf = 4'd0;
        `RIS_OFS_TIMER2_CLK: regOf = 4'd1;
        `RIS_OFS_CAPTURE_1_2: regOf = 4'd2;
        `RIS_OFS_CAPTURE_3_4: regOf = 4'd3;
        `RIS_OFS_COMPARE_FAULT: regOf = 4'd4;
        `RIS_OFS_PWM_FAULT: regOf = 4'd5;
        `RIS_OFS_SERIAL1_RX: regOf = 4'd6;
        `RIS_OFS_SERIAL2_RX: regOf = 4'd7;
        `RIS_OFS_SPI2_CLK_DATA: regOf = 4'd8;
        `RIS_OFS_ROUTED_LEVELS: regOf = REG_LEVELS;
        default: regOf = REG_NONE;
      endcase
    end
  endfunction

  // selector held in bits 7-0 of a register
  function [3:0] loSelOf;
    input [3:0] r;
    begin
      case (r)
        4'd0: loSelOf = S_IRQ2; // R1
        4'd1: loSelOf = S_T2CLK; // R2
        4'd2: loSelOf = S_CAP1; // R3
        4'd3: loSelOf = S_CAP3; // R3
        4'd4: loSelOf = S_CMPF; // R4
        4'd5: loSelOf = S_FLT1; // R5
        4'd6: loSelOf = S_SER1; // R6
        4'd7: loSelOf = S_SER2; // R7
        4'd8: loSelOf = S_SPID; // R8
        default: loSelOf = SEL_NONE;
      endcase
    end
  endfunction

  // selector held in bits 15-8, SEL_NONE where the byte is unimplemented
  function [3:0] hiSelOf;
    input [3:0] r;
    begin
      case (r)
        4'd2: hiSelOf = S_CAP2; // R3
        4'd3: hiSelOf = S_CAP4; // R3
        4'd5: hiSelOf = S_FLT2; // R5
        4'd8: hiSelOf = S_SPIC; // R8
        default: hiSelOf = SEL_NONE; // R13
      endcase
    end
  endfunction

  assign setupPhase = psel & ~penable;
  assign accessWrite = psel & penable & pwrite;
  assign setupReg = regOf(paddr);
  assign accessReg = regOf(paddr);

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & errFlag;

  // byte-lane write enables per slot; a refused access enables none
  always @* begin
    loWrite = {NUM_SEL{1'b0}};
    hiWrite = {NUM_SEL{1'b0}};
    for (j = 0; j < NUM_SEL; j = j + 1) begin
      if (accessWrite && !errFlag) begin
        loWrite[j] = pstrb[0] && (loSelOf(accessReg) == j[3:0]);
        // single-selector registers have no upper slot, so that byte is dropped
        hiWrite[j] = pstrb[1] && (hiSelOf(accessReg) == j[3:0]); // R13
      end
    end
  end

  // selector fields; one field per byte lane, strobes gate each lane
  always @(posedge sys_clk) begin
    if (rst) begin
      for (i = 0; i < NUM_SEL; i = i + 1) begin
        selField[i] <= `RIS_SEL_RESET; // R15
      end
    end else begin
      for (i = 0; i < NUM_SEL; i = i + 1) begin
        if (loWrite[i]) begin
          selField[i] <= pwdata[`RIS_FIELD_LO_LSB +: `RIS_FIELD_W]; // R19
        end
        if (hiWrite[i]) begin
          selField[i] <= pwdata[`RIS_FIELD_HI_LSB +: `RIS_FIELD_W]; // R13 R19
        end
      end
    end
  end

  // read word assembled from the fields, or from the routed levels for the levels word; all other bits stay zero
  always @* begin
    next_prdata = 32'h00000000; // R14
    if (setupReg == REG_LEVELS) begin
      next_prdata[NUM_SEL-1:0] = routedAll;
    end else if (setupReg != REG_NONE) begin
      if (loSelOf(setupReg) != SEL_NONE) begin
        next_prdata[`RIS_FIELD_LO_LSB +: `RIS_FIELD_W] = selField[loSelOf(setupReg)]; // R19
      end
      if (hiSelOf(setupReg) != SEL_NONE) begin
        next_prdata[`RIS_FIELD_HI_LSB +: `RIS_FIELD_W] = selField[hiSelOf(setupReg)]; // R19
      end
    end
  end

  // read data and error are latched in the setup cycle so they stand as flops
  always @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      errFlag <= 1'b0;
    end else if (setupPhase) begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
      // the levels word is read only; a write to it is refused
      errFlag <= (setupReg == REG_NONE) || (pwrite && setupReg == REG_LEVELS);
    end
  end

  // one shared synchroniser bank; every selector taps the same stage
  always @(posedge sys_clk) begin
    if (rst) begin
      pinMeta <= {(PIN_HI-1){1'b0}};
      pinSync <= {(PIN_HI-1){1'b0}};
      cmpMeta <= 1'b0;
      cmpSync <= 1'b0;
    end else begin
      pinMeta <= remappablePin;
      pinSync <= pinMeta; // R18
      cmpMeta <= comparatorOneOutput;
      cmpSync <= cmpMeta; // R18
    end
  end

  // selectors are independent, so any number may name the same pin
  ris_source_mux #(
    .PIN_HI(PIN_HI)
  ) u_irq2_mux (
    .selCode(selField[S_IRQ2]),
    .pinLevel(pinSync), // R16
    .cmpLevel(cmpSync),
    .routed(routedAll[S_IRQ2])
  );
  ris_source_mux #(
    .PIN_HI(PIN_HI)
  ) u_t2clk_mux (
    .selCode(selField[S_T2CLK]),
    .pinLevel(pinSync), // R16
    .cmpLevel(cmpSync),
    .routed(routedAll[S_T2CLK])
  );
  ris_source_mux #(
    .PIN_HI(PIN_HI)
  ) u_cap1_mux (
    .selCode(selField[S_CAP1]),
    .pinLevel(pinSync), // R16
    .cmpLevel(cmpSync),
    .routed(routedAll[S_CAP1])
  );
  ris_source_mux #(
    .PIN_HI(PIN_HI)
  ) u_cap2_mux (
    .selCode(selField[S_CAP2]),
    .pinLevel(pinSync), // R16
    .cmpLevel(cmpSync),
    .routed(routedAll[S_CAP2])
  );
  ris_source_mux #(
    .PIN_HI(PIN_HI)
  ) u_cap3_mux (
    .selCode(selField[S_CAP3]),
    .pinLevel(pinSync), // R16
    .cmpLevel(cmpSync),
    .routed(routedAll[S_CAP3])
  );
  ris_source_mux #(
    .PIN_HI(PIN_HI)
  ) u_cap4_mux (
    .selCode(selField[S_CAP4]),
    .pinLevel(pinSync), // R16
    .cmpLevel(cmpSync),
    .routed(routedAll[S_CAP4])
  );
  ris_source_mux #(
    .PIN_HI(PIN_HI)
  ) u_cmpf_mux (
    .selCode(selField[S_CMPF]),
    .pinLevel(pinSync), // R16
    .cmpLevel(cmpSync),
    .routed(routedAll[S_CMPF])
  );
  ris_source_mux #(
    .PIN_HI(PIN_HI)
  ) u_flt1_mux (
    .selCode(selField[S_FLT1]),
    .pinLevel(pinSync), // R16
    .cmpLevel(cmpSync),
    .routed(routedAll[S_FLT1])
  );
  ris_source_mux #(
    .PIN_HI(PIN_HI)
  ) u_flt2_mux (
    .selCode(selField[S_FLT2]),
    .pinLevel(pinSync), // R16
    .cmpLevel(cmpSync),
    .routed(routedAll[S_FLT2])
  );
  ris_source_mux #(
    .PIN_HI(PIN_HI)
  ) u_ser1_mux (
    .selCode(selField[S_SER1]),
    .pinLevel(pinSync), // R16
    .cmpLevel(cmpSync),
    .routed(routedAll[S_SER1])
  );
  ris_source_mux #(
    .PIN_HI(PIN_HI)
  ) u_ser2_mux (
    .selCode(selField[S_SER2]),
    .pinLevel(pinSync), // R16
    .cmpLevel(cmpSync),
    .routed(routedAll[S_SER2])
  );
  ris_source_mux #(
    .PIN_HI(PIN_HI)
  ) u_spid_mux (
    .selCode(selField[S_SPID]),
    .pinLevel(pinSync), // R16
    .cmpLevel(cmpSync),
    .routed(routedAll[S_SPID])
  );
  ris_source_mux #(
    .PIN_HI(PIN_HI)
  ) u_spic_mux (
    .selCode(selField[S_SPIC]),
    .pinLevel(pinSync), // R16
    .cmpLevel(cmpSync),
    .routed(routedAll[S_SPIC])
  );

  assign externalInterruptTwo = routedAll[S_IRQ2]; // R1
  assign timer2ExternalClock = routedAll[S_T2CLK]; // R2
  assign captureInput1 = routedAll[S_CAP1]; // R3
  assign captureInput2 = routedAll[S_CAP2]; // R3
  assign captureInput3 = routedAll[S_CAP3]; // R3
  assign captureInput4 = routedAll[S_CAP4]; // R3
  assign compareFaultAInput = routedAll[S_CMPF]; // R4
  assign pwmFault1Input = routedAll[S_FLT1]; // R5
  assign pwmFault2Input = routedAll[S_FLT2]; // R5
  assign serial1ReceiveInput = routedAll[S_SER1]; // R6
  assign serial2ReceiveInput = routedAll[S_SER2]; // R7
  assign spi2DataInput = routedAll[S_SPID]; // R9
  assign spi2ClockInput = routedAll[S_SPIC]; // R8

endmodule

// >>> dv/ris_input_select_sva.sv
`timescale 1ns/100ps
`include "ris_map.vh"
module ris_input_select_sva #(
  parameter ADDR_W = 12, // address width
  parameter PIN_HI = 181 // top pin code
) (
  input wire sys_clk, // clock
  input wire rst, // reset
  input wire psel, // select
  input wire penable, // access
  input wire pwrite, // write
  input wire [ADDR_W-1:0] paddr, // address
  input wire [31:0] pwdata, // write data
  input wire [3:0] pstrb, // strobes
  input wire pready, // ready
  input wire [31:0] prdata, // read data
  input wire pslverr, // error
  input wire [PIN_HI:2] remappablePin, // pins
  input wire comparatorOneOutput, // comparator
  input wire externalInterruptTwo, // routed
  input wire timer2ExternalClock, // routed
  input wire serial1ReceiveInput, // routed
  input wire serial2ReceiveInput // routed
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire accPhase = psel && penable;
  wire wrLo = accPhase && pwrite && pstrb[0];
  ready_always_a: assert property (pready) else $error("pready low");
  err_in_access_a: assert property (pslverr |-> accPhase) else $error("stray pslverr");
  unmapped_err_a: assert property (accPhase && paddr > `RIS_OFS_ROUTED_LEVELS |-> pslverr)
    else $error("unmapped access not refused");
  upper_zero_a: assert property (accPhase && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  single_hi_a: assert property (accPhase && !pwrite && paddr == `RIS_OFS_SERIAL1_RX
    |-> prdata[15:8] == 8'h00) else $error("unused byte not zero");
  reset_clear_a: assert property ($fell(rst) |-> !externalInterruptTwo && !serial2ReceiveInput)
    else $error("routed input high after reset");
  ground_code_a: assert property (wrLo && paddr == `RIS_OFS_EXT_IRQ2 && pwdata[7:0] == 8'h00
    |=> !externalInterruptTwo) else $error("ground code not low");
  cmp_code_a: assert property (wrLo && paddr == `RIS_OFS_TIMER2_CLK && pwdata[7:0] == 8'h01
    |=> timer2ExternalClock == $past(comparatorOneOutput, 2)) else $error("comparator not routed");
  top_code_a: assert property (wrLo && paddr == `RIS_OFS_SERIAL1_RX && pwdata[7:0] == 8'hB5
    |=> serial1ReceiveInput == $past(remappablePin[181], 2)) else $error("top pin not routed");
  undef_code_a: assert property (wrLo && paddr == `RIS_OFS_SERIAL2_RX && pwdata[7:0] == 8'hB6
    |=> !serial2ReceiveInput) else $error("undefined code not low");
  cover property (wrLo);
  cover property (accPhase && !pwrite);
  cover property (pslverr);
endmodule
bind ris_input_select ris_input_select_sva #(.ADDR_W(ADDR_W), .PIN_HI(PIN_HI)) sva (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .remappablePin(remappablePin),
  .comparatorOneOutput(comparatorOneOutput), .externalInterruptTwo(externalInterruptTwo),
  .timer2ExternalClock(timer2ExternalClock), .serial1ReceiveInput(serial1ReceiveInput),
  .serial2ReceiveInput(serial2ReceiveInput));

// >>> dv/remappable_input_selector_test.sv
`timescale 1ns/100ps
`include "ris_map.vh"
module remappable_input_selector_test;
  reg sys_clk = 1'h0;
  reg rst = 1'h1;
  reg psel = 1'h0;
  reg penable = 1'h0;
  reg pwrite = 1'h0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg [3:0] pstrb = 4'h0;
  reg [181:2] remappablePin = 180'h0;
  reg comparatorOneOutput = 1'h0;
  wire pready;
  wire pslverr;
  wire [31:0] prdata;
  wire [12:0] outs;
  wire [31:0] outw = {19'h00000, outs};
  // registers with one selector, indexed by word
  reg [8:0] single = 9'h0D3;
  // per routed output: register index nibble and high-byte flag
  reg [51:0] fieldReg = 52'h8876554332210;
  reg [12:0] fieldHi = 13'h1128;
  integer miscompares = 0;
  integer checks = 0;
  integer i;
  reg [11:0] a;
  reg [31:0] rd;
  reg err;
  reg [7:0] code;
  ris_input_select DUT (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .remappablePin(remappablePin),
    .comparatorOneOutput(comparatorOneOutput), .externalInterruptTwo(outs[0]),
    .timer2ExternalClock(outs[1]), .captureInput1(outs[2]), .captureInput2(outs[3]),
    .captureInput3(outs[4]), .captureInput4(outs[5]), .compareFaultAInput(outs[6]),
    .pwmFault1Input(outs[7]), .pwmFault2Input(outs[8]), .serial1ReceiveInput(outs[9]),
    .serial2ReceiveInput(outs[10]), .spi2DataInput(outs[11]), .spi2ClockInput(outs[12]));
  initial forever #20 sys_clk = ~sys_clk;
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task acc(input w, input [11:0] ad, input [31:0] d, input [3:0] s);
    begin
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      pstrb <= s;
      @(posedge sys_clk);
      penable <= 1'h1;
      @(posedge sys_clk);
      while (pready !== 1'h1) @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task stop_test;
    begin
      if (miscompares == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #400000;
    miscompares = miscompares + 1;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    chk(outw, 32'h00000000);
    for (a = 12'h000; a < 12'h024; a = a + 12'h004) begin
      acc(1'h0, a, 32'h00000000, 4'h0);
      chk(rd, 32'h00000000);
      acc(1'h1, a, 32'hFFFFFFFF, 4'hF);
      acc(1'h0, a, 32'h00000000, 4'h0);
      chk(rd, single[a[5:2]] ? 32'h000000FF : 32'h0000FFFF);
      code = 8'h0A + {3'h0, a[5:2], 1'h0};
      acc(1'h1, a, {16'h0000, code + 8'h01, code}, 4'hF);
    end
    // a lane whose strobe is low keeps its old byte
    acc(1'h1, 12'h008, 32'h00000000, 4'h1);
    acc(1'h0, 12'h008, 32'h00000000, 4'h0);
    chk(rd, 32'h00000F00);
    acc(1'h1, 12'h008, 32'h00000F0E, 4'hF);
    for (i = 0; i < 13; i = i + 1) begin
      code = 8'h0A + {3'h0, fieldReg[i*4 +: 4], 1'h0} + {7'h00, fieldHi[i]};
      remappablePin <= {179'h0, 1'h1} << (code - 8'h02);
      // two synchroniser stages plus the sampling edge
      repeat (3) @(posedge sys_clk);
      chk(outw, 32'h00000001 << i);
      acc(1'h0, `RIS_OFS_ROUTED_LEVELS, 32'h00000000, 4'h0);
      chk(rd, 32'h00000001 << i);
    end
    remappablePin <= {1'h1, 179'h0};
    comparatorOneOutput <= 1'h1;
    for (i = 0; i < 4; i = i + 1) begin
      code = i == 0 ? 8'hB5 : i == 1 ? 8'h01 : i == 2 ? 8'hB6 : 8'h00;
      for (a = 12'h000; a < 12'h024; a = a + 12'h004)
        acc(1'h1, a, {16'h0000, code, code}, 4'hF);
      @(posedge sys_clk);
      chk(outw, i < 2 ? 32'h00001FFF : 32'h00000000);
    end
    acc(1'h0, 12'h028, 32'h00000000, 4'h0);
    chk({31'h0, err}, 32'h00000001);
    acc(1'h1, `RIS_OFS_ROUTED_LEVELS, 32'hFFFFFFFF, 4'hF);
    chk({31'h0, err}, 32'h00000001);
    stop_test;
  end
endmodule
